// ---- dfs_pkg.sv ----
`default_nettype none
package dfs_pkg;

   // ----------------------------------------------------------------
   // spreading code and scrambler
   // ----------------------------------------------------------------
   // chips left to right are bit 10 down to bit 0, +1 coded as 1
   localparam logic [10:0] BARKER_CODE = 11'h5B8;
   localparam logic [3:0] LAST_CHIP = 4'hA;
   localparam logic [6:0] SCR_SEED = 7'h10;
   localparam int SCR_TAP_A = 3;
   localparam int SCR_TAP_B = 6;

   // ----------------------------------------------------------------
   // frame field lengths in symbols
   // ----------------------------------------------------------------
   localparam logic [6:0] TRAIN_LAST = 7'h75;
   localparam logic [6:0] DELIM_LAST = 7'h03;
   localparam logic [6:0] CARR_LAST = 7'h07;
   localparam logic [6:0] NID_LAST = 7'h0F;
   localparam logic [6:0] ED_NONDATA_SYMS = 7'h02;
   localparam logic [3:0] NID_MSB = 4'hF;

   // ----------------------------------------------------------------
   // phase jumps in quarter turns
   // ----------------------------------------------------------------
   localparam logic [1:0] JUMP_0 = 2'h0;
   localparam logic [1:0] JUMP_P90 = 2'h1;
   localparam logic [1:0] JUMP_180 = 2'h2;
   localparam logic [1:0] JUMP_M90 = 2'h3;
   localparam logic [1:0] PHASE_INIT = 2'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int CHIP_RATE_HZ = 11_000_000;
   localparam int RATE_UNIT_HZ = 1_000_000;
   localparam logic [5:0] ACC_STEP = 6'(CHIP_RATE_HZ / RATE_UNIT_HZ);
   localparam logic [5:0] ACC_MOD = 6'(SYS_CLK_HZ / RATE_UNIT_HZ);

   // ----------------------------------------------------------------
   // management word layout
   // ----------------------------------------------------------------
   localparam logic [4:0] MG_LAST_BIT = 5'h1F;
   localparam int MG_TXL_MSB = 15;
   localparam int MG_TXL_LSB = 9;
   localparam int MG_RXT_MSB = 8;
   localparam int MG_RXT_LSB = 1;
   localparam int MG_RATE_BIT = 0;

   typedef enum logic [2:0] {
      FLD_IDLE,
      FLD_TRAIN,
      FLD_SD,
      FLD_CARR,
      FLD_NID,
      FLD_BODY,
      FLD_ED
   } dfs_field_e;

endpackage
`default_nettype wire

// ---- dfs_frame_spreader.sv ----
`timescale 1ns/1ns
`default_nettype none
module dfs_frame_spreader
   import dfs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic tx_start,
   input wire logic [15:0] network_identifier,
   input wire logic tx_bit,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   output logic tx_busy,
   output logic tx_underrun,
   output logic chip_valid,
   output logic chip_i,
   output logic chip_q,
   output logic chip_nondata,
   input wire logic mgmt_clk,
   input wire logic mgmt_ctl,
   output logic mgmt_sta,
   output logic [6:0] tx_level,
   output logic [7:0] rx_threshold,
   output logic rate_reduced,
   input wire logic [7:0] rx_level,
   input wire logic [7:0] rx_quality,
   input wire logic [7:0] rx_noise,
   input wire logic rx_rate_reduced
);

   typedef struct packed {
      dfs_field_e fld;
      logic [6:0] cnt;
      logic [3:0] chip;
      logic [5:0] acc;
      logic [6:0] scr;
      logic [1:0] q;
      logic nd;
      logic rate_low;
      logic [15:0] network_ident_select;
      logic [1:0] nb;
      logic [1:0] ncnt;
      logic last_seen;
      logic underrun;
      logic cv;
      logic ci;
      logic cq;
      logic cnd;
      logic [1:0] mck_s;
      logic [1:0] mct_s;
      logic mck_prev;
      logic [4:0] mcnt;
      logic [15:0] ctl_sh;
      logic [31:0] sta_sh;
      logic [6:0] txl;
      logic [7:0] rxt;
      logic rate_sel;
   } dfs_state_s;

   dfs_state_s st_reg;
   dfs_state_s st_next;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // returns {scrambled bit, new register}
   function automatic logic [7:0] scr_step(input logic [6:0] s, input logic b);
      logic o;
      o = b ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      return {o, s[5:0], o};
   endfunction

   function automatic logic [1:0] map_normal(input logic d0, input logic d1);
      logic [1:0] j;
      unique case ({d0, d1})
         2'b00: j = JUMP_0;
         2'b01: j = JUMP_P90;
         2'b11: j = JUMP_180;
         default: j = JUMP_M90;
      endcase
      return j;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [5:0] acc_sum;
      logic tick;
      logic boundary;
      logic take;
      logic [1:0] need;
      logic have;
      logic do_sym;
      logic body_first;
      logic [6:0] s;
      logic [7:0] sr;
      logic sd0;
      logic sd1;
      logic [1:0] jump;
      logic [1:0] q_in;
      logic sym_nd;
      logic code_chip;
      logic nid_bit;
      logic mrise;
      st_next = st_reg;
      acc_sum = st_reg.acc + ACC_STEP;
      tick = 1'b0;
      do_sym = 1'b0;
      body_first = 1'b0;
      s = st_reg.scr;
      sr = 8'h00;
      sd0 = 1'b0;
      sd1 = 1'b0;
      jump = JUMP_0;
      q_in = st_reg.q;
      sym_nd = 1'b0;
      code_chip = 1'b0;
      nid_bit = 1'b0;
      need = st_reg.rate_low ? 2'h1 : 2'h2;
      have = (st_reg.ncnt == need) || (st_reg.last_seen && st_reg.ncnt != 2'h0);

      // chip tick: 11 of every 20 clocks on average
      if (acc_sum >= ACC_MOD) begin
         tick = 1'b1;
         st_next.acc = acc_sum - ACC_MOD;
      end else begin
         st_next.acc = acc_sum;
      end
      boundary = tick && st_reg.chip == LAST_CHIP && st_reg.fld != FLD_IDLE;

      // body bits are gathered ahead of the symbol that uses them
      tx_ready = (st_reg.fld == FLD_NID || st_reg.fld == FLD_BODY) && st_reg.ncnt < need
                 && !st_reg.last_seen && !boundary;
      take = tx_ready && tx_valid;
      if (take) begin
         st_next.nb[st_reg.ncnt[0]] = tx_bit;
         st_next.ncnt = st_reg.ncnt + 2'h1;
         st_next.last_seen = tx_last;
      end

      // ----------------------------------------------------------------
      // chip output
      // ----------------------------------------------------------------
      st_next.cv = 1'b0;
      if (tick && st_reg.fld != FLD_IDLE) begin
         if (st_reg.nd) begin
            code_chip = BARKER_CODE[st_reg.chip];
         end else begin
            code_chip = BARKER_CODE[LAST_CHIP - st_reg.chip];
         end
         st_next.cv = 1'b1;
         st_next.ci = code_chip ^ ~(st_reg.q == 2'h0 || st_reg.q == 2'h3);
         st_next.cq = code_chip ^ ~(st_reg.q == 2'h0 || st_reg.q == 2'h1);
         st_next.cnd = st_reg.nd;
         st_next.chip = st_reg.chip + 4'h1;
      end

      // ----------------------------------------------------------------
      // field sequencing
      // ----------------------------------------------------------------
      if (st_reg.fld == FLD_IDLE) begin
         if (tx_start) begin
            st_next.fld = FLD_TRAIN;
            st_next.cnt = 7'h00;
            st_next.chip = 4'h0;
            st_next.network_ident_select = network_identifier;
            st_next.rate_low = st_reg.rate_sel;
            st_next.underrun = 1'b0;
            st_next.last_seen = 1'b0;
            st_next.ncnt = 2'h0;
            st_next.nb = 2'h0;
            s = SCR_SEED;
            q_in = PHASE_INIT;
            do_sym = 1'b1;
         end
      end else if (boundary) begin
         st_next.chip = 4'h0;
         do_sym = 1'b1;
         st_next.cnt = st_reg.cnt + 7'h01;
         unique case (st_reg.fld)
            FLD_TRAIN: begin
               if (st_reg.cnt == TRAIN_LAST) begin
                  st_next.fld = FLD_SD;
                  st_next.cnt = 7'h00;
               end
            end
            FLD_SD: begin
               if (st_reg.cnt == DELIM_LAST) begin
                  st_next.fld = FLD_CARR;
                  st_next.cnt = 7'h00;
               end
            end
            FLD_CARR: begin
               if (st_reg.cnt == CARR_LAST) begin
                  st_next.fld = FLD_NID;
                  st_next.cnt = 7'h00;
               end
            end
            FLD_NID, FLD_BODY: begin
               if (st_reg.fld == FLD_BODY || st_reg.cnt == NID_LAST) begin
                  st_next.cnt = 7'h00;
                  if (have) begin
                     st_next.fld = FLD_BODY;
                     body_first = st_reg.fld != FLD_BODY;
                  end else begin
                     st_next.fld = FLD_ED;
                     st_next.underrun = !st_reg.last_seen;
                  end
               end
            end
            FLD_ED: begin
               if (st_reg.cnt == DELIM_LAST) begin
                  st_next.fld = FLD_IDLE;
                  st_next.cnt = 7'h00;
                  do_sym = 1'b0;
               end
            end
            default: begin
               st_next.fld = FLD_IDLE;
               do_sym = 1'b0;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // symbol build for the field just entered
      // ----------------------------------------------------------------
      if (do_sym) begin
         unique case (st_next.fld)
            FLD_TRAIN: begin
               sr = scr_step(s, 1'b0);
               sd0 = sr[7];
               sr = scr_step(sr[6:0], 1'b1);
               s = sr[6:0];
               jump = sd0 ? JUMP_M90 : JUMP_P90;
            end
            FLD_SD: begin
               jump = map_normal(1'b0, 1'b1);
               sym_nd = st_next.cnt == 7'h00;
            end
            FLD_CARR: begin
               jump = map_normal(1'b1, 1'b0);
            end
            FLD_NID: begin
               nid_bit = st_reg.network_ident_select[NID_MSB - st_next.cnt[3:0]];
               jump = nid_bit ? map_normal(1'b1, 1'b0) : map_normal(1'b0, 1'b1);
            end
            FLD_BODY: begin
               if (body_first) begin
                  s = SCR_SEED;
               end
               sr = scr_step(s, st_reg.nb[0]);
               sd0 = sr[7];
               s = sr[6:0];
               if (st_reg.rate_low) begin
                  jump = sd0 ? JUMP_M90 : JUMP_P90;
               end else begin
                  sr = scr_step(s, st_reg.nb[1]);
                  sd1 = sr[7];
                  s = sr[6:0];
                  jump = map_normal(sd0, sd1);
               end
               st_next.nb = 2'h0;
               st_next.ncnt = 2'h0;
            end
            FLD_ED: begin
               jump = map_normal(1'b0, 1'b1);
               sym_nd = st_next.cnt < ED_NONDATA_SYMS;
            end
            default: begin
               jump = JUMP_0;
            end
         endcase
         st_next.scr = s;
         st_next.q = q_in + jump;
         st_next.nd = sym_nd;
      end

      // ----------------------------------------------------------------
      // management port
      // ----------------------------------------------------------------
      st_next.mck_s = {st_reg.mck_s[0], mgmt_clk};
      st_next.mct_s = {st_reg.mct_s[0], mgmt_ctl};
      st_next.mck_prev = st_reg.mck_s[1];
      mrise = st_reg.mck_s[1] && !st_reg.mck_prev;
      if (mrise) begin
         st_next.ctl_sh = {st_reg.ctl_sh[14:0], st_reg.mct_s[1]};
         st_next.sta_sh = {st_reg.sta_sh[30:0], 1'b0};
         st_next.mcnt = st_reg.mcnt + 5'h01;
         if (st_reg.mcnt == MG_LAST_BIT) begin
            st_next.txl = st_next.ctl_sh[MG_TXL_MSB:MG_TXL_LSB];
            st_next.rxt = st_next.ctl_sh[MG_RXT_MSB:MG_RXT_LSB];
            st_next.rate_sel = st_next.ctl_sh[MG_RATE_BIT];
            st_next.sta_sh = {rx_level, rx_quality, rx_noise, 7'h00, rx_rate_reduced};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign tx_busy = st_reg.fld != FLD_IDLE;
   assign tx_underrun = st_reg.underrun;
   assign chip_valid = st_reg.cv;
   assign chip_i = st_reg.ci;
   assign chip_q = st_reg.cq;
   assign chip_nondata = st_reg.cnd;
   assign mgmt_sta = st_reg.sta_sh[31];
   assign tx_level = st_reg.txl;
   assign rx_threshold = st_reg.rxt;
   assign rate_reduced = st_reg.rate_sel;

endmodule
`default_nettype wire

// ---- dfs_frame_spreader_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module dfs_frame_spreader_sva
   import dfs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic tx_start,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_busy,
   input wire logic tx_underrun,
   input wire logic chip_valid,
   input wire logic chip_i,
   input wire logic chip_q,
   input wire logic mgmt_clk,
   input wire logic [6:0] tx_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic [1:0] gap_reg;
   // idle clocks between chips within a frame
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gap_reg <= 2'h0;
      end else if (tx_busy && !chip_valid && gap_reg != 2'h3) begin
         gap_reg <= gap_reg + 2'h1;
      end else if (!(tx_busy && !chip_valid)) begin
         gap_reg <= 2'h0;
      end
   end
   sequence s_start;
      tx_start && !tx_busy;
   endsequence
   sequence s_take2;
      (tx_valid && tx_ready) ##1 (tx_valid && tx_ready);
   endsequence
   a_start_busy: assert property (s_start |=> tx_busy) else $error("frame start not taken");
   a_underrun_clear: assert property (s_start |=> !tx_underrun) else $error("underrun not cleared");
   a_first_chip: assert property ($rose(tx_busy) |-> ##[1:2] chip_valid) else $error("first chip late");
   a_chip_gap: assert property (gap_reg <= 2'h2) else $error("gap in chip stream");
   a_chip_hold: assert property (!chip_valid |-> $stable({chip_i, chip_q})) else $error("chip moved idle");
   a_ready_drop: assert property (s_take2 |=> !tx_ready) else $error("more than a dibit taken");
   a_ready_busy: assert property (tx_ready |-> tx_busy) else $error("ready outside frame");
   a_idle_quiet: assert property (!tx_busy && !$past(tx_busy) && !$past(tx_busy, 2) |-> !chip_valid)
      else $error("chip outside frame");
   a_ctl_change: assert property ($changed(tx_level) |-> $past(mgmt_clk) || $past(mgmt_clk, 2)
      || $past(mgmt_clk, 3) || $past(mgmt_clk, 4) || $past(mgmt_clk, 5) || $past(mgmt_clk, 6))
      else $error("level changed without shift");
endmodule
bind dfs_frame_spreader dfs_frame_spreader_sva chk (.sys_clk, .rstn, .tx_start, .tx_valid, .tx_ready, .tx_busy,
   .tx_underrun, .chip_valid, .chip_i, .chip_q, .mgmt_clk, .tx_level);
`default_nettype wire

// ---- dfs_mac_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module dfs_mac_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic slow,
   input wire logic tx_ready,
   output logic tx_bit,
   output logic tx_valid,
   output logic tx_last
);
   logic [1:0] q[$];
   logic [1:0] gap = 2'h0;
   initial begin
      tx_bit = 1'b0;
      tx_valid = 1'b0;
      tx_last = 1'b0;
   end
   always @(posedge sys_clk) begin
      if (!rstn) begin
         tx_valid <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         void'(q.pop_front());
         gap <= slow ? 2'h3 : 2'h0;
         if (!slow && q.size() > 0) begin
            {tx_bit, tx_last} <= q[0];
         end else begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            tx_bit <= ~tx_bit;
         end
      end else if (gap != 2'h0) begin
         gap <= gap - 2'h1;
      end else if (!tx_valid && q.size() > 0) begin
         {tx_bit, tx_last} <= q[0];
         tx_valid <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import dfs_pkg::*;
   localparam logic [10:0] CODE = 11'h5B8;
   logic sys_clk = 1'b0, rstn = 1'b0, tx_start = 1'b0, slow = 1'b0, mgmt_clk = 1'b0, mgmt_ctl = 1'b0, rx_rr = 1'b0;
   logic [15:0] network_ident_select = 16'h0000;
   logic [7:0] rx_level = 8'h00, rx_quality = 8'h00, rx_noise = 8'h00, rnd = 8'h52;
   logic tx_bit, tx_valid, tx_last, tx_ready, tx_busy, tx_underrun, chip_valid, chip_i, chip_q, chip_nondata;
   logic mgmt_sta, rate_reduced;
   logic [6:0] tx_level;
   logic [7:0] rx_threshold;
   logic [2:0] exp_q[$];
   logic [6:0] scr;
   logic [1:0] ph;
   logic [31:0] w, st;
   int failures = 0, tests_run = 0, cycles = 0;

   always #25 sys_clk = ~sys_clk;

   dfs_frame_spreader dut (.sys_clk, .rstn, .tx_start, .network_identifier(network_ident_select), .tx_bit, .tx_valid, .tx_last,
      .tx_ready, .tx_busy, .tx_underrun, .chip_valid, .chip_i, .chip_q, .chip_nondata, .mgmt_clk, .mgmt_ctl,
      .mgmt_sta, .tx_level, .rx_threshold, .rate_reduced, .rx_level, .rx_quality, .rx_noise,
      .rx_rate_reduced(rx_rr));
   dfs_mac_model mac (.sys_clk, .rstn, .slow, .tx_ready, .tx_bit, .tx_valid, .tx_last);

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic scramble(input logic b, output logic o);
      o = b ^ scr[3] ^ scr[6];
      scr = {scr[5:0], o};
   endtask

   // one symbol: phase step, then eleven expected chips
   task automatic sym(input logic [1:0] j, input logic nd);
      logic ii, qq;
      ph = ph + j;
      ii = (ph == 2'h0 || ph == 2'h3);
      qq = (ph < 2'h2);
      for (int k = 0; k < 11; k++) begin
         exp_q.push_back({~(CODE[nd ? k : 10 - k] ^ ii), ~(CODE[nd ? k : 10 - k] ^ qq), nd});
      end
   endtask

   task automatic frame(input int nbits, input logic last, input logic stall);
      logic d0, d1;
      logic [15:0] n;
      n = {rnd, lfsr(rnd)};
      rnd = lfsr(lfsr(rnd));
      scr = 7'h10;
      ph = 2'h0;
      repeat (118) begin
         scramble(1'b0, d0);
         scramble(1'b1, d1);
         sym(d0 ? 2'h3 : 2'h1, 1'b0);
      end
      sym(2'h1, 1'b1);
      repeat (3) sym(2'h1, 1'b0);
      repeat (8) sym(2'h3, 1'b0);
      for (int k = 15; k >= 0; k--) sym(n[k] ? 2'h3 : 2'h1, 1'b0);
      scr = 7'h10;
      for (int k = 0; k < nbits; k += 2) begin
         rnd = lfsr(rnd);
         mac.q.push_back({rnd[0], 1'b0});
         mac.q.push_back({rnd[1], last && k == nbits - 2});
         scramble(rnd[0], d0);
         scramble(rnd[1], d1);
         sym(d0 ? (d1 ? 2'h2 : 2'h3) : {1'b0, d1}, 1'b0);
      end
      repeat (2) sym(2'h1, 1'b1);
      repeat (2) sym(2'h1, 1'b0);
      @(posedge sys_clk);
      slow <= stall;
      tx_start <= 1'b1;
      network_ident_select <= n;
      @(posedge sys_clk);
      tx_start <= 1'b0;
      repeat (50) @(posedge sys_clk);
      tx_start <= 1'b1;
      network_ident_select <= ~n;
      @(posedge sys_clk);
      tx_start <= 1'b0;
      while (tx_busy !== 1'b0) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      check("chips_left", exp_q.size(), 0);
      check("underrun", tx_underrun, !last);
   endtask

   task automatic mgmt_word(input logic [31:0] v, output logic [31:0] s);
      for (int k = 31; k >= 0; k--) begin
         s[k] = mgmt_sta;
         mgmt_ctl <= v[k];
         repeat (4) @(posedge sys_clk);
         mgmt_clk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         mgmt_clk <= 1'b0;
      end
      repeat (8) @(posedge sys_clk);
   endtask

   always @(negedge sys_clk) begin
      if (rstn && chip_valid !== 1'b0) begin
         if (exp_q.size() == 0) check("chip_extra", 1, 0);
         else check("chip", {chip_i, chip_q, chip_nondata}, exp_q.pop_front());
      end
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("CHECK FAILED timeout expected done seen running");
         final_report();
      end
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      rx_level <= lfsr(rnd);
      rx_quality <= lfsr(lfsr(rnd));
      rx_noise <= ~rnd;
      rx_rr <= rnd[1];
      @(posedge sys_clk);
      for (int m = 0; m < 2; m++) begin
         rnd = lfsr(rnd);
         w = {~rnd, lfsr(rnd), rnd[7:1], m == 0};
         mgmt_word(w, st);
         check("tx_level", tx_level, w[15:9]);
         check("rx_threshold", rx_threshold, w[8:1]);
         check("rate_reduced", rate_reduced, w[0]);
         if (m == 1) check("status", st, {rx_level, rx_quality, rx_noise, 7'h00, rx_rr});
      end
      frame(10, 1'b1, 1'b0);
      frame(6, 1'b0, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire
